//--- design/fltm_top.sv
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fltm_top
  import fltm_pkg::*;
#(
  parameter int unsigned UV_TICKS = fltm_pkg::UV_SUSTAIN_TICKS,
  parameter int unsigned FRAME_TICKS = fltm_pkg::FRAME_TO_TICKS,
  parameter int unsigned GL_W = fltm_pkg::GL_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog comparator and mode inputs, asynchronous
  input wire logic ground_sense_pin,
  input wire logic hold_cap_supply_low,
  input wire logic regulator_cap_node_low,
  input wire logic bus_below_frame,
  input wire logic test_mode,
  // Fault inputs from the fuse array logic, same clock
  input wire logic fuse_fault,
  input wire logic parity_fault,
  // Status and control outputs
  output logic undervoltage_flag,
  output logic accel_status_flag,
  output logic ground_fault_flag,
  output logic zero_accel,
  output logic self_test_lockout,
  output logic self_test_stim_on,
  output logic bus_switch_closed,
  output logic device_in_reset,
  output logic spi_din,
  output logic adc_from_filter_pin
);
  localparam int unsigned TMAX = (UV_TICKS > FRAME_TICKS) ? UV_TICKS : FRAME_TICKS;
  localparam int unsigned TW = $clog2(TMAX + 1);
  localparam logic [TW-1:0] UV_LAST = TW'(UV_TICKS - 1);
  localparam logic [TW-1:0] FRAME_LAST = TW'(FRAME_TICKS - 1);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic tick;
    logic [TW-1:0] uv_cnt;
    logic uv_sustained;
    logic [TW-1:0] fr_cnt;
    logic frame_to;
    logic in_reset;
    logic [31:0] cfg;
    logic last_dis;
    logic lockout;
    logic stim_on;
    logic switch_closed;
    logic u_flag;
    logic s_flag;
    logic gnd_flt_flag;
    logic zero_accel;
    logic spi_din;
    logic adc_sel;
    logic waitreq;
    logic [31:0] rdata;
  } fltm_top_state_t;

  fltm_top_state_t s_reg;
  fltm_top_state_t s_next;

  logic [4:0] pins_s;
  logic gs_s;
  logic hold_cap_low_s;
  logic reg_node_low_s;
  logic frame_low_s;
  logic test_s;
  logic [31:0] status_word;

  fltm_glc_if #(.W(GL_W)) glc ();

  // All comparator and mode pins pass two flip-flops before any logic sees them.
  fltm_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({ground_sense_pin, hold_cap_supply_low, regulator_cap_node_low,
               bus_below_frame, test_mode}),
    .sync_out(pins_s)
  );

  assign gs_s = pins_s[4];
  assign hold_cap_low_s = pins_s[3];
  assign reg_node_low_s = pins_s[2];
  assign frame_low_s = pins_s[1];
  assign test_s = pins_s[0];

  // The detector is held cleared whenever it is disabled, in test mode or in reset.
  assign glc.tick = s_reg.tick;
  assign glc.clr = ~s_reg.cfg[CFG_GND_LOSS_EN_BIT] | test_s | s_reg.in_reset;
  assign glc.up = gs_s;

  fltm_updown #(.W(GL_W)) u_glc (
    .clk(clk),
    .rst_b(rst_b),
    .glc(glc)
  );

  // Status word shown to software.
  always_comb begin
    status_word = '0;
    status_word[ST_U_BIT] = s_reg.u_flag;
    status_word[ST_S_BIT] = s_reg.s_flag;
    status_word[ST_GND_FAULT_BIT] = s_reg.gnd_flt_flag;
    status_word[ST_ZERO_BIT] = s_reg.zero_accel;
    status_word[ST_LOCK_BIT] = s_reg.lockout;
    status_word[ST_SWITCH_BIT] = s_reg.switch_closed;
    status_word[ST_RESET_BIT] = s_reg.in_reset;
    status_word[ST_GLOSS_BIT] = glc.loss;
    status_word[ST_STIM_BIT] = s_reg.stim_on;
    status_word[ST_TEST_BIT] = test_s;
  end

  // Next-state logic for bus slave, timers, fault flags and command handling.
  always_comb begin
    logic wr_fire;
    logic cmd_fire;
    logic clr_cmd;
    logic u_cond;
    logic s_cond;
    logic gnd_flt_cond;
    logic [31:0] wd;
    wr_fire = 1'b0;
    cmd_fire = 1'b0;
    clr_cmd = 1'b0;
    u_cond = 1'b0;
    s_cond = 1'b0;
    gnd_flt_cond = 1'b0;
    wd = avs_writedata;
    s_next = s_reg;

    // Oscillator-rate tick, one clock wide.
    s_next.tick = 1'b0;
    if (s_reg.presc == PRESC_LAST) begin
      s_next.presc = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.presc = s_reg.presc + 1'b1;
    end

    // Persistence timers restart the moment their condition goes away.
    if (!hold_cap_low_s) begin
      s_next.uv_cnt = '0;
      s_next.uv_sustained = 1'b0;
    end else if (s_reg.tick && !s_reg.uv_sustained) begin
      if (s_reg.uv_cnt == UV_LAST) begin
        s_next.uv_sustained = 1'b1;
      end else begin
        s_next.uv_cnt = s_reg.uv_cnt + 1'b1;
      end
    end
    if (!frame_low_s) begin
      s_next.fr_cnt = '0;
      s_next.frame_to = 1'b0;
    end else if (s_reg.tick && !s_reg.frame_to) begin
      if (s_reg.fr_cnt == FRAME_LAST) begin
        s_next.frame_to = 1'b1;
      end else begin
        s_next.fr_cnt = s_reg.fr_cnt + 1'b1;
      end
    end
    s_next.in_reset = reg_node_low_s | s_reg.uv_sustained | s_reg.frame_to;

    // Bus slave: one wait cycle, then the access completes.
    s_next.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      if (avs_read) begin
        if (avs_address == ADDR_CONFIG) begin
          s_next.rdata = s_reg.cfg;
        end else if (avs_address == ADDR_STATUS) begin
          s_next.rdata = status_word;
        end else if (avs_address == ADDR_GLCOUNT) begin
          s_next.rdata = 32'(glc.count);
        end else begin
          s_next.rdata = '0;
        end
      end
    end
    wr_fire = avs_write && !s_reg.waitreq;
    for (int i = 0; i < 4; i++) begin
      if (!avs_byteenable[i]) begin
        wd[8*i +: 8] = 8'h00;
      end
    end
    if (wr_fire && avs_address == ADDR_CONFIG) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          s_next.cfg[8*i +: 8] = avs_writedata[8*i +: 8];
        end
      end
      s_next.cfg = s_next.cfg & CFG_MASK;
    end
    // Commands are dropped while the device sits in reset, as the link would see.
    cmd_fire = wr_fire && (avs_address == ADDR_COMMAND) && !s_reg.in_reset;

    // Command decode, one command per write, Clear taking priority.
    if (cmd_fire) begin
      if (wd[CMD_CLEAR_BIT]) begin
        clr_cmd = 1'b1;
        s_next.last_dis = 1'b0;
      end else if (wd[CMD_ST_DIS_BIT]) begin
        s_next.stim_on = 1'b0;
        s_next.last_dis = 1'b1;
        if (s_reg.last_dis) begin
          s_next.lockout = 1'b1;
        end
      end else if (wd[CMD_ST_EN_BIT]) begin
        s_next.last_dis = 1'b0;
        s_next.stim_on = ~s_reg.lockout;
      end else if (wd[CMD_INIT_BIT] || wd[CMD_REV_INIT_BIT]) begin
        s_next.last_dis = 1'b0;
        if (wd[CMD_D6_BIT]) begin
          s_next.switch_closed = 1'b1;
        end
      end else if (wd[CMD_OTHER_BIT]) begin
        s_next.last_dis = 1'b0;
      end
    end

    // Fault qualification; set always wins over a simultaneous Clear.
    u_cond = hold_cap_low_s;
    gnd_flt_cond = glc.loss;
    s_cond = fuse_fault | parity_fault | glc.loss;
    if (s_reg.lockout) begin
      s_next.u_flag = u_cond | (s_reg.u_flag & ~clr_cmd);
      s_next.s_flag = s_cond | (s_reg.s_flag & ~clr_cmd);
      s_next.gnd_flt_flag = gnd_flt_cond | (s_reg.gnd_flt_flag & ~clr_cmd);
    end else begin
      s_next.u_flag = u_cond;
      s_next.s_flag = s_cond;
      s_next.gnd_flt_flag = gnd_flt_cond;
    end
    s_next.zero_accel = s_next.u_flag | s_next.s_flag;

    // Test-mode pin reuse.
    s_next.spi_din = test_s & gs_s;
    s_next.adc_sel = test_s & s_reg.cfg[CFG_ADC_SEL_BIT];

    // Continuous reset wipes device state but keeps the bus slave alive for software.
    if (s_reg.in_reset) begin
      s_next.switch_closed = 1'b0;
      s_next.lockout = 1'b0;
      s_next.last_dis = 1'b0;
      s_next.stim_on = 1'b0;
      s_next.u_flag = 1'b0;
      s_next.s_flag = 1'b0;
      s_next.gnd_flt_flag = 1'b0;
      s_next.zero_accel = 1'b0;
    end
  end

  // State register; power-on reset leaves the switch open, waitrequest high and everything else cleared.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output comes straight from the state register.
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign undervoltage_flag = s_reg.u_flag;
  assign accel_status_flag = s_reg.s_flag;
  assign ground_fault_flag = s_reg.gnd_flt_flag;
  assign zero_accel = s_reg.zero_accel;
  assign self_test_lockout = s_reg.lockout;
  assign self_test_stim_on = s_reg.stim_on;
  assign bus_switch_closed = s_reg.switch_closed;
  assign device_in_reset = s_reg.in_reset;
  assign spi_din = s_reg.spi_din;
  assign adc_from_filter_pin = s_reg.adc_sel;
endmodule : fltm_top
`default_nettype wire

//--- include/fltm_pkg.sv
package fltm_pkg;

  // Clock and oscillator timing; the logic clock is divided down to the oscillator rate.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OSC_PERIOD_NS = 250;
  localparam int unsigned PRESC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W = 3;

  // Ground-loss debounce counter width; its overflow time is 2**14 oscillator ticks.
  localparam int unsigned GL_CNT_W = 14;

  // Undervoltage persistence and frame timeout, both counted in oscillator ticks.
  localparam int unsigned UV_SUSTAIN_NS = 1000000;
  localparam int unsigned UV_SUSTAIN_TICKS = UV_SUSTAIN_NS / OSC_PERIOD_NS;
  localparam int unsigned FRAME_TO_NS = 1000000;
  localparam int unsigned FRAME_TO_TICKS = FRAME_TO_NS / OSC_PERIOD_NS;

  // Register byte addresses.
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COMMAND = 4'h8;
  localparam logic [3:0] ADDR_GLCOUNT = 4'hc;

  // Configuration register: low byte is device_config_byte_two, bit 8 routes the ADC.
  localparam int unsigned CFG_GND_LOSS_EN_BIT = 5;
  localparam int unsigned CFG_ADC_SEL_BIT = 8;
  localparam logic [31:0] CFG_MASK = 32'h0000_01ff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Status register bit positions.
  localparam int unsigned ST_U_BIT = 0;
  localparam int unsigned ST_S_BIT = 1;
  localparam int unsigned ST_GND_FAULT_BIT = 2;
  localparam int unsigned ST_ZERO_BIT = 3;
  localparam int unsigned ST_LOCK_BIT = 4;
  localparam int unsigned ST_SWITCH_BIT = 5;
  localparam int unsigned ST_RESET_BIT = 6;
  localparam int unsigned ST_GLOSS_BIT = 7;
  localparam int unsigned ST_STIM_BIT = 8;
  localparam int unsigned ST_TEST_BIT = 9;

  // Command register bit positions; D6 of the command data byte sits at bit 14.
  localparam int unsigned CMD_CLEAR_BIT = 0;
  localparam int unsigned CMD_ST_DIS_BIT = 1;
  localparam int unsigned CMD_ST_EN_BIT = 2;
  localparam int unsigned CMD_INIT_BIT = 3;
  localparam int unsigned CMD_REV_INIT_BIT = 4;
  localparam int unsigned CMD_OTHER_BIT = 5;
  localparam int unsigned CMD_D6_BIT = 14;

endpackage : fltm_pkg

//--- include/fltm_glc_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the ground-loss debounce counter controls and results.
interface fltm_glc_if #(
  parameter int unsigned W = 14
);
  logic tick;
  logic clr;
  logic up;
  logic [W-1:0] count;
  logic loss;

  modport ctr (input tick, input clr, input up, output count, output loss);
  modport user (output tick, output clr, output up, input count, input loss);
endinterface : fltm_glc_if
`default_nettype wire

//--- design/fltm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fltm_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fltm_sync_state_t;

  fltm_sync_state_t s_reg;
  fltm_sync_state_t s_next;

  // The first stage feeds only the second stage, so metastability cannot leak.
  always_comb begin
    s_next = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.s2;
endmodule : fltm_sync
`default_nettype wire

//--- design/fltm_updown.sv
`timescale 1ns/1ps
`default_nettype none
module fltm_updown #(
  parameter int unsigned W = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Counter controls and results
  fltm_glc_if.ctr glc
);
  typedef struct packed {
    logic [W-1:0] count;
    logic loss;
  } fltm_updown_state_t;

  fltm_updown_state_t s_reg;
  fltm_updown_state_t s_next;

  // Up/down filter: a brief open only moves the count, it never flags by itself.
  always_comb begin
    s_next = s_reg;
    if (glc.clr) begin
      s_next = '0;
    end else if (glc.tick) begin
      if (glc.up) begin
        if (&s_reg.count) begin
          s_next.loss = 1'b1;
        end else begin
          s_next.count = s_reg.count + 1'b1;
        end
      end else if (s_reg.count != '0) begin
        s_next.count = s_reg.count - 1'b1;
      end else begin
        s_next.loss = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign glc.count = s_reg.count;
  assign glc.loss = s_reg.loss;
endmodule : fltm_updown
`default_nettype wire

//--- dv/fltm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fltm_sva
  import fltm_pkg::*;
#(
  parameter int unsigned UV_TICKS = 8,
  parameter int unsigned FRAME_TICKS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Conditions
  input wire logic hold_cap_supply_low,
  input wire logic regulator_cap_node_low,
  input wire logic bus_below_frame,
  input wire logic test_mode,
  input wire logic fuse_fault,
  input wire logic parity_fault,
  // Status outputs
  input wire logic undervoltage_flag,
  input wire logic accel_status_flag,
  input wire logic ground_fault_flag,
  input wire logic zero_accel,
  input wire logic self_test_lockout,
  input wire logic bus_switch_closed,
  input wire logic device_in_reset,
  input wire logic spi_din,
  input wire logic adc_from_filter_pin
);
  // Slack covers two sync stages, the prescaler phase and the state register.
  localparam int HC_LIM = UV_TICKS * PRESC_DIV + 12;
  localparam int FR_LIM = FRAME_TICKS * PRESC_DIV + 12;
  typedef struct packed {logic [15:0] hc; logic [15:0] fr;} fltm_run_t;
  fltm_run_t run_reg, run_next;
  wire logic cmd_wr = avs_write && !avs_waitrequest && avs_address == ADDR_COMMAND;

  // Consecutive cycles of the hold-cap supply low and bus-below-frame conditions.
  always_comb begin
    run_next = run_reg;
    run_next.hc = hold_cap_supply_low ? run_reg.hc + 16'h1 : 16'h0;
    run_next.fr = bus_below_frame ? run_reg.fr + 16'h1 : 16'h0;
  end

  // Counters restart with every reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= '0;
    end else begin
      run_reg <= run_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_ZERO_ACCEL: assert property (zero_accel == (undervoltage_flag || accel_status_flag))
    else $error("zero_accel differs from U or S");
  AST_GND_FAULT_SETS_S: assert property (ground_fault_flag |-> accel_status_flag)
    else $error("ground fault without status flag");
  AST_FUSE_S: assert property ((fuse_fault || parity_fault) [*2] |->
    ##[0:2] (accel_status_flag || device_in_reset)) else $error("fuse fault not flagged");
  AST_UV_FLAG: assert property (hold_cap_supply_low [*4] |->
    ##[0:2] (undervoltage_flag || device_in_reset)) else $error("undervoltage not flagged");
  AST_UV_HOLD: assert property (run_reg.hc == 16'(HC_LIM) |-> device_in_reset)
    else $error("sustained undervoltage without reset");
  AST_FRAME_TO: assert property (run_reg.fr == 16'(FR_LIM) |-> device_in_reset)
    else $error("frame timeout without reset");
  AST_REG_LOW: assert property (regulator_cap_node_low [*4] |-> ##[0:2] device_in_reset)
    else $error("regulator low without reset");
  AST_QUIET: assert property (device_in_reset ##1 device_in_reset |-> !bus_switch_closed &&
    !undervoltage_flag && !accel_status_flag && !self_test_lockout)
    else $error("state not cleared in reset");
  AST_SWITCH: assert property ($rose(bus_switch_closed) |-> $past(cmd_wr &&
    avs_byteenable[1] && avs_writedata[CMD_D6_BIT] && avs_byteenable[0] &&
    (avs_writedata[CMD_INIT_BIT] || avs_writedata[CMD_REV_INIT_BIT])))
    else $error("switch closed without init and D6");
  AST_LOCK: assert property ($rose(self_test_lockout) |->
    $past(cmd_wr && avs_byteenable[0] && avs_writedata[CMD_ST_DIS_BIT]))
    else $error("lockout without disable command");
  AST_TEST_PINS: assert property (!test_mode [*4] |-> !spi_din && !adc_from_filter_pin)
    else $error("test pins active outside test mode");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");

  CV_LOCK: cover property ($rose(self_test_lockout));
  CV_GND_FAULT: cover property ($rose(ground_fault_flag));
  CV_RST: cover property ($rose(device_in_reset));
endmodule : fltm_sva

bind fltm_top fltm_sva #(.UV_TICKS(UV_TICKS), .FRAME_TICKS(FRAME_TICKS)) sva_u (
  .clk, .rst_b, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .hold_cap_supply_low, .regulator_cap_node_low, .bus_below_frame,
  .test_mode, .fuse_fault, .parity_fault, .undervoltage_flag, .accel_status_flag,
  .ground_fault_flag, .zero_accel, .self_test_lockout, .bus_switch_closed,
  .device_in_reset, .spi_din, .adc_from_filter_pin);
`default_nettype wire

//--- dv/fltm_dsi_master.sv
`timescale 1ns/1ps
`default_nettype none
module fltm_dsi_master (
  // Clock
  input wire logic clk,
  // Bus master side
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest
);
  // Byte lanes for the next transfer; the bench narrows them to test lane masking.
  logic [3:0] lanes;

  // Single-ended bus only, so ground-loss results are trusted here.
  initial begin
    lanes = 4'hf;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  // One transfer; released lines carry inverted data so stale values never match.
  task automatic xfer(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= lanes;
    avs_read <= is_rd;
    avs_write <= !is_rd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : fltm_dsi_master
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fltm_pkg::*;
  localparam int GW = 4;
  logic clk, rst_b, sense, hc_low, reg_low, frm_low, tmode, fuse, par, rd, wr, wt;
  logic [3:0] addr, be;
  logic [31:0] wd, rdat, v;
  logic u, s, gnd_flt, z, lock, stim, sw, inr, spi, adc;
  int n_errors = 0;
  int checked = 0;
  logic [63:0] exp_q[$];

  fltm_top #(.UV_TICKS(8), .FRAME_TICKS(8), .GL_W(GW)) dut_u (
    .clk(clk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
    .ground_sense_pin(sense), .hold_cap_supply_low(hc_low),
    .regulator_cap_node_low(reg_low), .bus_below_frame(frm_low), .test_mode(tmode),
    .fuse_fault(fuse), .parity_fault(par), .undervoltage_flag(u), .accel_status_flag(s),
    .ground_fault_flag(gnd_flt), .zero_accel(z), .self_test_lockout(lock),
    .self_test_stim_on(stim), .bus_switch_closed(sw), .device_in_reset(inr),
    .spi_din(spi), .adc_from_filter_pin(adc));
  fltm_dsi_master mst_u (.clk(clk), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_waitrequest(wt));

  // Free-running bus clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction : b

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({e, m});
    mst_u.xfer(1'b1, a, 32'h0);
  endtask : rd_chk

  task automatic cmd(input logic [31:0] d);
    mst_u.xfer(1'b0, ADDR_COMMAND, d);
  endtask : cmd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic chk(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic stop_test();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Each completed read is compared, under its mask, with the oldest note.
  always @(posedge clk) begin : mon
    logic [63:0] x;
    if (rd === 1'b1 && wt === 1'b0) begin
      x = exp_q.pop_front();
      checked++;
      if ((rdat & x[31:0]) !== x[63:32]) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, rdat & x[31:0], x[63:32]);
      end
    end
  end

  // A hang is cut short; the sequence needs under 3000 cycles.
  initial begin
    repeat (10000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {sense, hc_low, reg_low, frm_low, tmode, fuse, par} = 7'h0;
    rst_b = 1'b0;
    void'($urandom(32'hf0eb));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(ADDR_CONFIG, CFG_RESET, '1);
    rd_chk(ADDR_STATUS, 32'h0, 32'h3ff);
    rd_chk(4'h2, 32'h0, '1);
    v = $urandom;
    mst_u.xfer(1'b0, ADDR_CONFIG, v);
    rd_chk(ADDR_CONFIG, v & CFG_MASK, '1);
    mst_u.xfer(1'b0, ADDR_CONFIG, 32'h0);
    sense <= 1'b1;
    idle(150);
    rd_chk(ADDR_GLCOUNT, 32'h0, '1);
    mst_u.xfer(1'b0, ADDR_CONFIG, b(CFG_GND_LOSS_EN_BIT));
    idle(30);
    rd_chk(ADDR_STATUS, 32'h0, 32'h84);
    idle(90);
    rd_chk(ADDR_GLCOUNT, 32'(2 ** GW - 1), '1);
    rd_chk(ADDR_STATUS, 32'h8e, 32'h8f);
    sense <= 1'b0;
    idle(30);
    rd_chk(ADDR_STATUS, 32'h4, 32'h4);
    idle(90);
    rd_chk(ADDR_GLCOUNT, 32'h0, '1);
    rd_chk(ADDR_STATUS, 32'h0, 32'h8e);
    // A reset in mid-run with the counter busy and the switch closed.
    sense <= 1'b1;
    cmd(b(CMD_INIT_BIT) | b(CMD_D6_BIT));
    rd_chk(ADDR_STATUS, 32'h20, 32'h20);
    idle(30);
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    sense <= 1'b0;
    rd_chk(ADDR_GLCOUNT, 32'h0, '1);
    rd_chk(ADDR_STATUS, 32'h0, 32'h20);
    hc_low <= 1'b1;
    idle(10);
    rd_chk(ADDR_STATUS, 32'h9, 32'h49);
    hc_low <= 1'b0;
    idle(5);
    rd_chk(ADDR_STATUS, 32'h0, 32'h9);
    // Each long supply fault forces reset, and commands sent meanwhile are lost.
    for (int i = 0; i < 3; i++) begin
      {frm_low, reg_low, hc_low} <= 3'(b(i));
      idle(60);
      rd_chk(ADDR_STATUS, 32'h40, 32'h61);
      cmd(b(CMD_INIT_BIT) | b(CMD_D6_BIT));
      {frm_low, reg_low, hc_low} <= 3'h0;
      idle(10);
      rd_chk(ADDR_STATUS, 32'h0, 32'h61);
    end
    for (int k = CMD_INIT_BIT; k <= CMD_REV_INIT_BIT; k++) begin
      cmd(b(k));
      rd_chk(ADDR_STATUS, 32'h0, 32'h20);
      cmd(b(k) | b(CMD_D6_BIT));
      rd_chk(ADDR_STATUS, 32'h20, 32'h20);
      reg_low <= 1'b1;
      idle(6);
      reg_low <= 1'b0;
      idle(4);
      rd_chk(ADDR_STATUS, 32'h0, 32'h20);
    end
    // D6 sits in byte lane one; with that lane masked the switch stays open.
    mst_u.lanes = 4'h1;
    cmd(b(CMD_INIT_BIT) | b(CMD_D6_BIT));
    mst_u.lanes = 4'hf;
    rd_chk(ADDR_STATUS, 32'h0, 32'h20);
    fuse <= 1'b1;
    idle(2);
    rd_chk(ADDR_STATUS, 32'ha, 32'he);
    fuse <= 1'b0;
    par <= 1'b1;
    idle(2);
    rd_chk(ADDR_STATUS, 32'h2, 32'h2);
    par <= 1'b0;
    idle(2);
    rd_chk(ADDR_STATUS, 32'h0, 32'ha);
    cmd(b(CMD_ST_EN_BIT));
    idle(1);
    chk(stim, 1'b1);
    cmd(b(CMD_ST_DIS_BIT));
    cmd(b(CMD_OTHER_BIT));
    cmd(b(CMD_ST_DIS_BIT));
    rd_chk(ADDR_STATUS, 32'h0, 32'h110);
    cmd(b(CMD_ST_DIS_BIT));
    cmd(b(CMD_ST_EN_BIT));
    rd_chk(ADDR_STATUS, 32'h10, 32'h110);
    chk(stim, 1'b0);
    chk(lock, 1'b1);
    fuse <= 1'b1;
    idle(3);
    fuse <= 1'b0;
    idle(5);
    cmd(b(CMD_INIT_BIT));
    rd_chk(ADDR_STATUS, 32'h2, 32'h2);
    cmd(b(CMD_CLEAR_BIT));
    rd_chk(ADDR_STATUS, 32'h10, 32'h12);
    tmode <= 1'b1;
    sense <= 1'b1;
    mst_u.xfer(1'b0, ADDR_CONFIG, b(CFG_ADC_SEL_BIT));
    idle(5);
    chk(spi, 1'b1);
    chk(adc, 1'b1);
    rd_chk(ADDR_STATUS, 32'h200, 32'h200);
    sense <= 1'b0;
    tmode <= 1'b0;
    idle(5);
    chk(spi, 1'b0);
    chk(adc, 1'b0);
    idle(4);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
